//--- verilog/hpm_pkg.sv
// Package of constants for the host port mode and global pin block
package hpm_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS   = 25000;
    localparam int unsigned RESET_MAX_NS    = 2000;
    localparam int unsigned RESET_CYCLES    = (RESET_MAX_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned RST_SEQ_CYCLES  = 16;

    // ------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------
    localparam int unsigned GPIO_DIR_LSB    = 0;
    localparam int unsigned GPIO_LEVEL_LSB  = 2;
    localparam int unsigned INT_OD_BIT      = 0;
    localparam int unsigned INT_POL_BIT     = 1;
    localparam int unsigned TERM_CODE_W     = 3;
    localparam int unsigned NUM_RX          = 22;
    localparam int unsigned ADDR_W          = 11;
    localparam int unsigned DATA_W          = 8;
    localparam int unsigned ADDR_HI_W       = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [1:0]  GPIO_DIR_RST    = 2'h0;
    localparam logic [1:0]  INT_CFG_RST     = 2'h0;

    // Host bus flavours decoded from the straps
    typedef enum logic [2:0] {
        HPM_SERIAL       = 3'h0,
        HPM_PAR_DS       = 3'h1,
        HPM_PAR_DS_MUX   = 3'h3,
        HPM_PAR_RDWR     = 3'h5,
        HPM_PAR_RDWR_MUX = 3'h7
    } hpm_mode_type;
endpackage

//--- verilog/hpm_sync.sv
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module hpm_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } hpm_sync_state_type;

    hpm_sync_state_type state;
    hpm_sync_state_type next_state;

    // First stage feeds only the second stage
    always_comb begin
        next_state.first  = din;
        next_state.second = state.first;
    end

    // No reset: straps must reach the core while reset is held
    always_ff @(posedge sys_clk) begin
        state <= next_state;
    end

    assign dout = state.second;
endmodule

//--- verilog/hpm_host_port.sv
// Host port mode decode, chip select, address latch, interrupt and global pin gating
`timescale 1ns/1ps
module hpm_host_port #(
    parameter int unsigned NUM_RX     = hpm_pkg::NUM_RX,
    parameter int unsigned NUM_IRQ    = 8,
    parameter int unsigned WAIT_CYC   = 2
) (
    input  wire logic                              sys_clk,
    input  wire logic                              nrst,
    input  wire logic                              bus_type_strap,
    input  wire logic                              parallel_flavor_strap,
    input  wire logic                              bus_multiplex_strap,
    input  wire logic                              chip_select_n,
    input  wire logic                              address_strobe_pin,
    input  wire logic                              strobe_pin,
    input  wire logic                              serial_data_in,
    input  wire logic [hpm_pkg::ADDR_W-1:0]        addr_pin,
    input  wire logic [hpm_pkg::DATA_W-1:0]        data_in,
    input  wire logic [1:0]                        gpio_dir,
    input  wire logic [1:0]                        gpio_level_wr,
    input  wire logic [1:0]                        gpio_pin_in,
    input  wire logic [1:0]                        int_pin_cfg,
    input  wire logic [NUM_IRQ-1:0]                irq_pending,
    input  wire logic [NUM_IRQ-1:0]                irq_mask,
    input  wire logic                              output_enable_pin,
    input  wire logic [NUM_RX-1:0]                 tx_driver_en_reg,
    input  wire logic                              rx_differential,
    input  wire logic                              receive_termination_gate,
    input  wire logic [NUM_RX*hpm_pkg::TERM_CODE_W-1:0] rx_term_code,
    input  wire logic [NUM_RX-1:0]                 rx_120ohm_internal,
    output logic [2:0]                             bus_mode,
    output logic                                   access_active,
    output logic                                   access_start,
    output logic [hpm_pkg::ADDR_W-1:0]             latched_addr,
    output logic                                   addr_valid,
    output logic                                   ready_out,
    output logic                                   serial_sample,
    output logic                                   serial_update,
    output logic                                   serial_bit,
    output logic [1:0]                             gpio_out,
    output logic [1:0]                             gpio_oe,
    output logic [1:0]                             gpio_level_rd,
    output logic                                   int_out,
    output logic                                   int_oe,
    output logic                                   reset_busy,
    output logic [NUM_RX-1:0]                      tx_driver_on,
    output logic [NUM_RX-1:0]                      rx_term_on,
    output logic [NUM_RX*hpm_pkg::TERM_CODE_W-1:0] rx_term_code_out,
    output logic [NUM_RX-1:0]                      rx_120ohm_on
);
    localparam int unsigned SYN_W = 8;
    localparam int unsigned TERM_W = NUM_RX * hpm_pkg::TERM_CODE_W;

    // ------------------------------------------------------------
    // Synchronised pin inputs
    // ------------------------------------------------------------
    logic [SYN_W-1:0] syn;
    logic [1:0]       gpio_syn;

    hpm_sync #(.WIDTH(SYN_W)) u_sync_ctl (
        .sys_clk (sys_clk),
        .din     ({bus_type_strap, parallel_flavor_strap, bus_multiplex_strap, chip_select_n,
                   address_strobe_pin, strobe_pin, serial_data_in, output_enable_pin}),
        .dout    (syn)
    );

    hpm_sync #(.WIDTH(2)) u_sync_gpio (
        .sys_clk (sys_clk),
        .din     (gpio_pin_in),
        .dout    (gpio_syn)
    );

    logic s_bus, s_flav, s_mux, s_cs_n, s_as, s_strb, s_sdi, s_oe;
    assign {s_bus, s_flav, s_mux, s_cs_n, s_as, s_strb, s_sdi, s_oe} = syn;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0]              mode;
        logic                    cs_n_d;
        logic                    as_d;
        logic                    strb_d;
        logic                    active;
        logic                    start;
        logic [hpm_pkg::ADDR_W-1:0] addr;
        logic                    addr_ok;
        logic [3:0]              wait_cnt;
        logic                    rdy;
        logic                    samp;
        logic                    upd;
        logic                    sbit;
        logic [1:0]              g_out;
        logic [1:0]              g_oe;
        logic [1:0]              g_rd;
        logic                    irq;
        logic                    irq_oe;
        logic [6:0]              rst_cnt;
        logic                    busy;
        logic [NUM_RX-1:0]       tx_on;
        logic [NUM_RX-1:0]       term_on;
        logic [TERM_W-1:0]       term_code;
        logic [NUM_RX-1:0]       r120;
    } hpm_state_type;

    hpm_state_type state;
    hpm_state_type next_state;

    logic irq_any;
    logic irq_level;
    logic cs_fall;
    logic as_fall;
    logic strb_fall;
    logic strb_rise;

    assign irq_any   = |(irq_pending & ~irq_mask);
    assign cs_fall   = state.cs_n_d & ~s_cs_n;
    assign as_fall   = state.as_d & ~s_as;
    assign strb_fall = state.strb_d & ~s_strb;
    assign strb_rise = ~state.strb_d & s_strb;
    assign irq_level = irq_any ~^ int_pin_cfg[hpm_pkg::INT_POL_BIT];

    // Next state; straps are only caught while reset is held
    always_comb begin
        next_state        = state;
        next_state.cs_n_d = s_cs_n;
        next_state.as_d   = s_as;
        next_state.strb_d = s_strb;
        next_state.start  = 1'b0;
        next_state.samp   = 1'b0;
        next_state.upd    = 1'b0;

        // Reset sequence counter, bounded well below the 2 us limit
        if (state.busy) begin
            if (state.rst_cnt == 7'(hpm_pkg::RST_SEQ_CYCLES - 1)) begin
                next_state.busy = 1'b0;
            end else begin
                next_state.rst_cnt = state.rst_cnt + 7'h01;
            end
        end

        // A fresh chip select edge opens an access; it stays open while low
        if (cs_fall && !state.busy) begin
            next_state.active   = 1'b1;
            next_state.start    = 1'b1;
            next_state.wait_cnt = 4'h0;
            next_state.rdy      = 1'b0;
            next_state.addr_ok  = 1'b0;
        end else if (s_cs_n) begin
            next_state.active  = 1'b0;
            next_state.rdy     = 1'b0;
            next_state.addr_ok = 1'b0;
        end

        // Multiplexed address capture from upper pins and data bus
        if (state.active && state.mode[0] && state.mode[1] && as_fall) begin
            next_state.addr    = {addr_pin[hpm_pkg::ADDR_W-1:hpm_pkg::DATA_W], data_in};
            next_state.addr_ok = 1'b1;
        end else if (state.active && !(state.mode[0] && state.mode[1])
                     && state.mode != 3'(hpm_pkg::HPM_SERIAL) && !state.addr_ok) begin
            next_state.addr    = addr_pin;
            next_state.addr_ok = 1'b1;
        end

        // Ready with separate strobes: wait states then release
        if (state.active && state.mode[2] && !s_strb) begin
            if (state.wait_cnt == 4'(WAIT_CYC)) begin
                next_state.rdy = 1'b1;
            end else begin
                next_state.wait_cnt = state.wait_cnt + 4'h1;
                next_state.rdy      = 1'b0;
            end
        end else if (state.active && s_strb) begin
            next_state.wait_cnt = 4'h0;
            next_state.rdy      = 1'b0;
        end

        // Serial: sample on rising, update on falling shift clock
        if (state.active && state.mode == 3'(hpm_pkg::HPM_SERIAL)) begin
            next_state.samp = strb_rise;
            next_state.upd  = strb_fall;
            if (strb_rise) begin
                next_state.sbit = s_sdi;
            end
        end

        // General purpose pins
        for (int i = 0; i < 2; i++) begin
            next_state.g_oe[i]  = gpio_dir[hpm_pkg::GPIO_DIR_LSB + i];
            next_state.g_out[i] = gpio_level_wr[i];
            next_state.g_rd[i]  = gpio_dir[i] ? gpio_level_wr[i] : gpio_syn[i];
        end

        // Interrupt pin: open drain drives only the active level
        if (int_pin_cfg[hpm_pkg::INT_OD_BIT]) begin
            next_state.irq    = irq_level;
            next_state.irq_oe = irq_any;
        end else begin
            next_state.irq    = irq_level;
            next_state.irq_oe = 1'b1;
        end

        // Line drivers and receive termination gating only touch the pin side
        next_state.tx_on = s_oe ? tx_driver_en_reg : '0;
        if (rx_differential && !receive_termination_gate) begin
            next_state.term_on   = '0;
            next_state.term_code = '0;
            next_state.r120      = '0;
        end else begin
            next_state.term_on   = '1;
            next_state.term_code = rx_term_code;
            next_state.r120      = rx_120ohm_internal;
        end

        if (!nrst) begin
            next_state         = '0;
            next_state.cs_n_d  = 1'b1;
            next_state.as_d    = 1'b1;
            next_state.strb_d  = 1'b1;
            next_state.busy    = 1'b1;
            next_state.g_oe    = hpm_pkg::GPIO_DIR_RST;
            // Straps sampled while reset is held
            next_state.mode    = s_bus ? {s_flav, s_mux, 1'b1} : 3'h0;
        end
    end

    // Register copy
    always_ff @(posedge sys_clk) begin
        state <= next_state;
    end

    assign bus_mode         = state.mode;
    assign access_active    = state.active;
    assign access_start     = state.start;
    assign latched_addr     = state.addr;
    assign addr_valid       = state.addr_ok;
    assign ready_out        = state.rdy;
    assign serial_sample    = state.samp;
    assign serial_update    = state.upd;
    assign serial_bit       = state.sbit;
    assign gpio_out         = state.g_out;
    assign gpio_oe          = state.g_oe;
    assign gpio_level_rd    = state.g_rd;
    assign int_out          = state.irq;
    assign int_oe           = state.irq_oe;
    assign reset_busy       = state.busy;
    assign tx_driver_on     = state.tx_on;
    assign rx_term_on       = state.term_on;
    assign rx_term_code_out = state.term_code;
    assign rx_120ohm_on     = state.r120;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_cs_edge;
        $fell(s_cs_n) && !state.busy;
    endsequence

    AST_RESET_DONE: assert property (@(posedge sys_clk) $rose(nrst) |-> ##[1:17] !reset_busy)
        else $error("reset sequence too long");
    // The first edge after release still shows reset values, so skip it
    AST_GPIO_DIR: assert property (@(posedge sys_clk) disable iff (!nrst)
        $past(nrst) |-> gpio_oe == $past(gpio_dir))
        else $error("gpio direction mismatch");
    AST_GPIO_OUT: assert property (@(posedge sys_clk) disable iff (!nrst)
        $past(nrst) && $past(gpio_dir[0]) |-> gpio_out[0] == $past(gpio_level_wr[0]))
        else $error("gpio output level wrong");
    AST_GPIO_IN: assert property (@(posedge sys_clk) disable iff (!nrst)
        $past(nrst) && !$past(gpio_dir[1]) |-> gpio_level_rd[1] == $past(gpio_syn[1]))
        else $error("gpio input level wrong");
    AST_IRQ_ACTIVE: assert property (@(posedge sys_clk) disable iff (!nrst)
        $past(nrst) && $past(irq_any) && $past(int_pin_cfg == 2'h2) |-> int_out && int_oe)
        else $error("interrupt not asserted");
    AST_IRQ_OD: assert property (@(posedge sys_clk) disable iff (!nrst)
        $past(int_pin_cfg[0]) && !$past(irq_any) |-> !int_oe)
        else $error("open drain drives idle");
    AST_CS_START: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_cs_edge |=> access_start ##1 !access_start)
        else $error("access start missing");
    AST_CS_END: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_cs_n |=> !access_active)
        else $error("access open without chip select");
    AST_TX_GATE: assert property (@(posedge sys_clk) disable iff (!nrst)
        !$past(s_oe) |-> tx_driver_on == '0)
        else $error("driver on while disabled");
    AST_RX_GATE: assert property (@(posedge sys_clk) disable iff (!nrst)
        $past(rx_differential && !receive_termination_gate) |-> rx_term_on == '0)
        else $error("termination not released");
    AST_RDY_WAIT: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_cs_edge |=> !ready_out)
        else $error("ready high at access start");
endmodule

//--- bench/hpm_host_model.sv
// Host processor model driving chip select, strobes and bus pins
`timescale 1ns/1ps
module hpm_host_model (
    input  wire logic        sys_clk,
    input  wire logic        ready_out,
    output logic             chip_select_n,
    output logic             address_strobe_pin,
    output logic             strobe_pin,
    output logic             serial_data_in,
    output logic [10:0]      addr_pin,
    output logic [7:0]       data_in
);
    // ------------------------------------------------------------
    // Idle levels: deselected, strobes high
    // ------------------------------------------------------------
    initial begin
        chip_select_n      = 1'b1;
        address_strobe_pin = 1'b1;
        strobe_pin         = 1'b1;
        serial_data_in     = 1'b0;
        addr_pin           = 11'h000;
        data_in            = 8'h00;
    end

    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // Short select pulse with no strobe, used to probe refusal windows
    task automatic cs_pulse(input int n);
        @(negedge sys_clk);
        chip_select_n = 1'b0;
        idle(n);
        chip_select_n = 1'b1;
    endtask

    // Strobe toggled while deselected; the port must stay deaf
    task automatic strobe_only(input int n);
        @(negedge sys_clk);
        strobe_pin = 1'b0;
        idle(n);
        strobe_pin = 1'b1;
    endtask

    // One access framed by its own select low period
    task automatic access(input logic par, input logic mux, input logic rdwr,
                          input logic [10:0] addr, input logic [7:0] data,
                          output int waited);
        waited = 0;
        @(negedge sys_clk);
        address_strobe_pin = par;
        addr_pin = mux ? {addr[10:8], ~addr[7:0]} : addr;
        data_in = mux ? addr[7:0] : data;
        chip_select_n = 1'b0;
        idle(4);
        if (mux) begin
            address_strobe_pin = 1'b0;
            idle(4);
            address_strobe_pin = 1'b1;
            data_in = data;
        end
        if (!par) begin
            // Shift clock only runs inside the frame and idles high
            for (int i = 7; i >= 0; i--) begin
                strobe_pin = 1'b0;
                serial_data_in = data[i];
                idle(4);
                strobe_pin = 1'b1;
                idle(4);
            end
            serial_data_in = ~data[0];
        end else begin
            strobe_pin = 1'b0;
            if (rdwr) begin
                // Hold the strobe until ready is sampled high, bounded
                while (ready_out !== 1'b1 && waited < 50) begin
                    @(posedge sys_clk);
                    waited++;
                end
                if (ready_out !== 1'b1) waited = -1;
            end else begin
                idle(6);
            end
        end
        idle(2);
        strobe_pin = 1'b1;
        chip_select_n = 1'b1;
        data_in = ~data_in;
        idle(4);
    endtask
endmodule

//--- bench/hpm_host_port_tb_top.sv
// Self-checking bench for the host port mode and global pin block
`timescale 1ns/1ps
module hpm_host_port_tb_top;
    // ------------------------------------------------------------
    // Constants, rows and signals
    // ------------------------------------------------------------
    localparam logic [65:0] TERM_CODE = 66'h1_2345_6789_ABCD_EF01;
    localparam logic [21:0] R120      = 22'h15A5A5;
    localparam logic [21:0] TX_EN     = 22'h3C3C3C;
    localparam int          WAIT      = 2;
    typedef struct packed {
        logic [1:0] dir, lvl, pin, icfg;
        logic [7:0] pend, mask;
        logic       oe, gate, exp_int, exp_tx;
    } hpm_row_type;
    typedef struct packed {
        logic       bt, fl, mx;
        logic [2:0] exp;
    } hpm_mode_row_type;
    // Mask bit high hides its source; open drain wire has a pull-up
    hpm_row_type rows [6] = '{
        '{2'h0, 2'h3, 2'h2, 2'h0, 8'h00, 8'h00, 1'b1, 1'b1, 1'b1, 1'b1},
        '{2'h3, 2'h1, 2'h0, 2'h1, 8'h10, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0},
        '{2'h1, 2'h2, 2'h2, 2'h2, 8'h81, 8'h01, 1'b1, 1'b0, 1'b1, 1'b1},
        '{2'h2, 2'h0, 2'h1, 2'h3, 8'hFF, 8'h7F, 1'b0, 1'b1, 1'b1, 1'b0},
        '{2'h1, 2'h3, 2'h3, 2'h0, 8'h04, 8'hFB, 1'b1, 1'b1, 1'b0, 1'b1},
        '{2'h2, 2'h1, 2'h2, 2'h1, 8'h00, 8'hFF, 1'b0, 1'b0, 1'b1, 1'b0}};
    hpm_mode_row_type modes [5] = '{
        '{1'b0, 1'b1, 1'b0, hpm_pkg::HPM_SERIAL},
        '{1'b1, 1'b0, 1'b0, hpm_pkg::HPM_PAR_DS},
        '{1'b1, 1'b0, 1'b1, hpm_pkg::HPM_PAR_DS_MUX},
        '{1'b1, 1'b1, 1'b0, hpm_pkg::HPM_PAR_RDWR},
        '{1'b1, 1'b1, 1'b1, hpm_pkg::HPM_PAR_RDWR_MUX}};
    logic        sys_clk, nrst, bus_type_strap, parallel_flavor_strap, bus_multiplex_strap;
    logic        chip_select_n, address_strobe_pin, strobe_pin, serial_data_in;
    logic        access_active, access_start, addr_valid, ready_out, serial_sample;
    logic        serial_update, serial_bit, int_out, int_oe, reset_busy, int_wire;
    logic        output_enable_pin, rx_differential, receive_termination_gate;
    logic [10:0] addr_pin, latched_addr;
    logic [7:0]  data_in, irq_pending, irq_mask;
    logic [2:0]  bus_mode;
    logic [1:0]  gpio_dir, gpio_level_wr, gpio_pin_in, int_pin_cfg;
    logic [1:0]  gpio_out, gpio_oe, gpio_level_rd;
    logic [21:0] tx_driver_en_reg, rx_120ohm_internal, tx_driver_on, rx_term_on, rx_120ohm_on;
    logic [65:0] rx_term_code, rx_term_code_out;
    int          errors, n_checks, n_start, n_samp, n_upd, n_rdy;

    // Open drain pin level as seen on a board with a pull-up
    assign int_wire = int_oe ? int_out : 1'b1;

    hpm_host_port #(.WAIT_CYC(WAIT)) hpm_host_port_inst (
        .sys_clk, .nrst, .bus_type_strap, .parallel_flavor_strap, .bus_multiplex_strap,
        .chip_select_n, .address_strobe_pin, .strobe_pin, .serial_data_in, .addr_pin,
        .data_in, .gpio_dir, .gpio_level_wr, .gpio_pin_in, .int_pin_cfg, .irq_pending,
        .irq_mask, .output_enable_pin, .tx_driver_en_reg, .rx_differential,
        .receive_termination_gate, .rx_term_code, .rx_120ohm_internal, .bus_mode,
        .access_active, .access_start, .latched_addr, .addr_valid, .ready_out,
        .serial_sample, .serial_update, .serial_bit, .gpio_out, .gpio_oe, .gpio_level_rd,
        .int_out, .int_oe, .reset_busy, .tx_driver_on, .rx_term_on, .rx_term_code_out,
        .rx_120ohm_on);

    hpm_host_model host_inst (
        .sys_clk, .ready_out, .chip_select_n, .address_strobe_pin, .strobe_pin,
        .serial_data_in, .addr_pin, .data_in);

    // ------------------------------------------------------------
    // Clock, event counters and watchdog
    // ------------------------------------------------------------
    always #12.5 sys_clk = ~sys_clk;
    // Pulses are counted on every rising edge so none slips between checks
    always @(posedge sys_clk) begin
        if (access_start === 1'b1) n_start++;
        if (serial_sample === 1'b1) n_samp++;
        if (serial_update === 1'b1) n_upd++;
        if (ready_out === 1'b1) n_rdy++;
    end
    initial begin
        repeat (60000) @(posedge sys_clk);
        errors++;
        wrap_up();
    end

    task automatic check(input logic [95:0] got, input logic [95:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Straps change only under reset; a select edge during busy is ignored
    task automatic do_reset(input hpm_mode_row_type m);
        int cnt;
        int s0;
        @(negedge sys_clk);
        nrst = 1'b0;
        {bus_type_strap, parallel_flavor_strap, bus_multiplex_strap} = {m.bt, m.fl, m.mx};
        repeat (8) @(negedge sys_clk);
        check(reset_busy, 1'b1);
        check({tx_driver_on, gpio_oe, access_active}, '0);
        nrst = 1'b1;
        s0 = n_start;
        host_inst.cs_pulse(4);
        cnt = 5;
        while (reset_busy !== 1'b0 && cnt < 200) begin
            @(negedge sys_clk);
            cnt++;
        end
        check(cnt <= hpm_pkg::RESET_CYCLES, 1'b1);
        repeat (6) @(negedge sys_clk);
        check(n_start - s0, 0);
        check(bus_mode, m.exp);
    endtask

    // ------------------------------------------------------------
    // Main sequence: row table, then modes, accesses and refusals
    // ------------------------------------------------------------
    initial begin
        int waited;
        int s0;
        int s1;
        int s2;
        sys_clk = 1'b0;
        nrst = 1'b0;
        {bus_type_strap, parallel_flavor_strap, bus_multiplex_strap} = 3'h6;
        {gpio_dir, gpio_level_wr, gpio_pin_in, int_pin_cfg} = 8'h3F;
        {irq_pending, irq_mask} = 16'hFF00;
        {output_enable_pin, rx_differential, receive_termination_gate} = 3'h7;
        tx_driver_en_reg = TX_EN;
        rx_term_code = TERM_CODE;
        rx_120ohm_internal = R120;
        {errors, n_checks, n_start, n_samp, n_upd, n_rdy} = '0;
        do_reset(modes[3]);
        foreach (rows[r]) begin
            @(negedge sys_clk);
            {gpio_dir, gpio_level_wr, gpio_pin_in, int_pin_cfg} = {rows[r].dir,
                rows[r].lvl, rows[r].pin, rows[r].icfg};
            {irq_pending, irq_mask} = {rows[r].pend, rows[r].mask};
            {output_enable_pin, receive_termination_gate} = {rows[r].oe, rows[r].gate};
            repeat (6) @(negedge sys_clk);
            check(gpio_oe, rows[r].dir);
            check(gpio_out & rows[r].dir, rows[r].lvl & rows[r].dir);
            check(gpio_level_rd & ~rows[r].dir, rows[r].pin & ~rows[r].dir);
            check(int_wire, rows[r].exp_int);
            if (!rows[r].icfg[0]) check(int_oe, 1'b1);
            check(tx_driver_on, rows[r].exp_tx ? TX_EN : 22'h000000);
            if (!rows[r].gate) check({rx_term_on, rx_120ohm_on}, '0);
            else check({rx_term_code_out, rx_120ohm_on}, {TERM_CODE, R120});
            if (rows[r].gate) check(rx_term_on, 22'h3FFFFF);
        end
        foreach (modes[i]) begin
            do_reset(modes[i]);
            {s0, s1, s2} = {n_start, n_samp, n_upd};
            host_inst.access(modes[i].bt, modes[i].mx, modes[i].fl, 11'h5A3 + 11'(i),
                             8'hC7, waited);
            check(n_start - s0, 1);
            check(access_active, 1'b0);
            if (modes[i].bt) check(latched_addr, 11'h5A3 + 11'(i));
            if (modes[i].bt && modes[i].fl) check(waited > WAIT, 1'b1);
            if (!modes[i].bt) check({n_samp - s1, n_upd - s2}, {32'd8, 32'd8});
            if (!modes[i].bt) check(serial_bit, 1'b1);
        end
        // Strobe with select high: no access and no ready
        {s0, s1} = {n_start, n_rdy};
        host_inst.strobe_only(8);
        repeat (4) @(negedge sys_clk);
        check({n_start - s0, n_rdy - s1}, '0);
        wrap_up();
    end
endmodule
